// File: verilog/wrap_monitor_pkg.sv
// How it works
// R1: Wrap lower bound sits below home by offset ratio times wrap range.
// R2: A signed step offset then shifts the whole wrap window.
// R3: Setting error flags when the shifted window no longer holds home.
// R4: Setting error becomes an alarm on power-up or configuration command.
// R5: Division pulse fires at each equal-division boundary referenced to home.
// R6: Division count is configurable, one to the top of range, default one.
// R7: Division pulse only while the wrap function is enabled.
// R8: A homed product at the stored end limit raises mechanical overtravel.
// R9: Limit setting one disables the stored end limit and its alarm.
// R10: Speed above stored starting or operating ceiling raises data error alarm.
// R11: Protection setting one disables speed ceilings and their alarm.
// R12: Either monitor request starts a serial transfer of position or alarm.
// R13: Serial output changes at the start of each shift clock pulse.
// R14: Every field goes out least significant bit first.
// R15: Positions are 32 bits, alarms 8 bits, then a checksum byte.
// R16: Checksum is the low eight bits of the sum of all data bytes.
// R17: Each request has its own payload code, 8 alarm, 9 to 12 position.
// R18: Host aligns by clearing its counter or reading the present position.
// R19: On request the device captures positions and alarm, then raises output.
// R20: Host waits for the output high and clocks no faster than 500 Hz; the host model clocks at 2.5 MHz.
// R21: Host drops the request when done and may stop before the checksum.
// R22: Dropping the request aborts the transfer and returns output low.
package wrap_monitor_pkg;

  localparam int POS_W = 32;
  localparam int ALM_W = 8;
  localparam int RATIO_W = 14;
  localparam logic [RATIO_W-1:0] RATIO_FULL = 14'h2710; // 10000 = 100.00 %
  localparam int DIV_W = 29;
  localparam logic [DIV_W-1:0] DIV_DEFAULT = 29'h0000001;
  localparam int SPD_W = 24;
  localparam int FRAME_W = 48; // Position, alarm, checksum

  // Payload selection codes
  localparam logic [3:0] SEL_ALARM = 4'h8;
  localparam logic [3:0] SEL_FB_POS = 4'h9;
  localparam logic [3:0] SEL_FB_CNT = 4'ha;
  localparam logic [3:0] SEL_CMD_POS = 4'hb;
  localparam logic [3:0] SEL_CMD_CNT = 4'hc;
  localparam logic [3:0] SEL_A_DEFAULT = 4'h8;
  localparam logic [3:0] SEL_B_DEFAULT = 4'h8;

  // Alarm codes, values arbitrary
  localparam logic [ALM_W-1:0] ALM_NONE = 8'h00;
  localparam logic [ALM_W-1:0] ALM_WRAP_SETTING = 8'h01;
  localparam logic [ALM_W-1:0] ALM_MECH_OVERTRAVEL = 8'h02;
  localparam logic [ALM_W-1:0] ALM_OP_DATA = 8'h03;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_LOAD = 2'b01,
    SER_SHIFT = 2'b11
  } ser_state_t;

  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [5:0] len;
  } frame_t;

endpackage

// File: verilog/wrap_coordinate_position_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wrap_coordinate_position_monitor
  import wrap_monitor_pkg::*;
#(
  parameter int POS_WIDTH = POS_W
) (
  input wire logic MCLK,
  input wire logic NRST,
  // Configuration
  input wire logic WRAP_ENABLE,
  input wire logic [POS_W-1:0] WRAP_RANGE_STEPS,
  input wire logic [RATIO_W-1:0] WRAP_OFFSET_RATIO,
  input wire logic [POS_W-1:0] WRAP_OFFSET_STEPS,
  input wire logic [DIV_W-1:0] DIVISION_COUNT,
  input wire logic LIMIT_DISABLE,
  input wire logic PROTECT_DISABLE,
  input wire logic [3:0] SELECT_A,
  input wire logic [3:0] SELECT_B,
  input wire logic CONFIG_EXECUTE,
  // Motion state
  input wire logic HOMED,
  input wire logic [POS_W-1:0] FEEDBACK_COUNTER,
  input wire logic [POS_W-1:0] COMMAND_COUNTER,
  input wire logic [POS_W-1:0] LIMIT_LOW,
  input wire logic [POS_W-1:0] LIMIT_HIGH,
  input wire logic [SPD_W-1:0] START_SPEED,
  input wire logic [SPD_W-1:0] RUN_SPEED,
  input wire logic [SPD_W-1:0] START_SPEED_MAX,
  input wire logic [SPD_W-1:0] RUN_SPEED_MAX,
  input wire logic MOVE_REQUEST,
  // Monitor link pins
  input wire logic monitor_request_a,
  input wire logic monitor_request_b,
  input wire logic monitor_shift_clock,
  output logic monitor_serial_out,
  // Status
  output logic WRAP_SETTING_INFO,
  output logic [ALM_W-1:0] ALARM_CODE,
  output logic wrap_division_pulse
);

  // ----------------------------------------
  // Wrap window arithmetic
  // ----------------------------------------
  logic signed [63:0] ratio_prod;
  logic signed [POS_W-1:0] lower_bound;
  logic signed [POS_W-1:0] upper_bound;
  logic signed [POS_W-1:0] fb_wrapped;
  logic signed [POS_W-1:0] cmd_wrapped;
  logic home_outside;

  // Window start shifted negative by ratio, then by the step offset
  assign ratio_prod = $signed({32'h0, WRAP_RANGE_STEPS}) * $signed({50'h0, WRAP_OFFSET_RATIO});
  assign lower_bound = POS_W'(-(ratio_prod / 64'sd10000))
                       + $signed(WRAP_OFFSET_STEPS); // [R1] [R2]
  assign upper_bound = lower_bound + $signed(WRAP_RANGE_STEPS) - 32'sd1;
  // Home must stay inside the window
  assign home_outside = (lower_bound > 32'sd0) || (upper_bound < 32'sd0)
                        || (WRAP_RANGE_STEPS == '0); // [R3]

  function automatic logic signed [POS_W-1:0] wrap_fold(input logic signed [POS_W-1:0] p);
    logic signed [POS_W-1:0] r;
    r = (p - lower_bound) % $signed(WRAP_RANGE_STEPS);
    if (r < 0) begin
      r = r + $signed(WRAP_RANGE_STEPS);
    end
    return r + lower_bound;
  endfunction

  assign fb_wrapped = (WRAP_ENABLE && !home_outside) ? wrap_fold(FEEDBACK_COUNTER)
                                                    : FEEDBACK_COUNTER;
  assign cmd_wrapped = (WRAP_ENABLE && !home_outside) ? wrap_fold(COMMAND_COUNTER)
                                                     : COMMAND_COUNTER;

  // ----------------------------------------
  // Setting error and alarms
  // ----------------------------------------
  logic first_cycle_reg;
  logic wrap_alarm_reg;
  logic mech_alarm_reg;
  logic op_alarm_reg;

  // Power-up: first cycle after reset counts as control power on
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      first_cycle_reg <= 1'b1;
    end else begin
      first_cycle_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      WRAP_SETTING_INFO <= 1'b0;
    end else begin
      WRAP_SETTING_INFO <= WRAP_ENABLE && home_outside; // [R3]
    end
  end

  // Escalation sampled only at power-up or configuration; stays until reset
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      wrap_alarm_reg <= 1'b0;
    end else if ((first_cycle_reg || CONFIG_EXECUTE) && WRAP_ENABLE && home_outside) begin
      wrap_alarm_reg <= 1'b1; // [R4]
    end
  end

  // Overtravel latches; cleared only by reset since the axis is out of range
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      mech_alarm_reg <= 1'b0;
    end else if (!LIMIT_DISABLE && HOMED
                 && ($signed(FEEDBACK_COUNTER) >= $signed(LIMIT_HIGH)
                     || $signed(FEEDBACK_COUNTER) <= $signed(LIMIT_LOW))) begin
      mech_alarm_reg <= 1'b1; // [R8] [R9]
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      op_alarm_reg <= 1'b0;
    end else if (!PROTECT_DISABLE && MOVE_REQUEST
                 && (START_SPEED > START_SPEED_MAX || RUN_SPEED > RUN_SPEED_MAX)) begin
      op_alarm_reg <= 1'b1; // [R10] [R11]
    end
  end

  // Highest priority alarm is reported
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ALARM_CODE <= ALM_NONE;
    end else if (wrap_alarm_reg) begin
      ALARM_CODE <= ALM_WRAP_SETTING;
    end else if (mech_alarm_reg) begin
      ALARM_CODE <= ALM_MECH_OVERTRAVEL;
    end else if (op_alarm_reg) begin
      ALARM_CODE <= ALM_OP_DATA;
    end else begin
      ALARM_CODE <= ALM_NONE;
    end
  end

  // ----------------------------------------
  // Division pulse
  // ----------------------------------------
  logic [POS_W-1:0] div_size;
  logic signed [POS_W-1:0] fb_rel;
  logic on_boundary;
  logic signed [POS_W-1:0] last_fb_reg;

  // Zero count treated as one division
  assign div_size = WRAP_RANGE_STEPS / ((DIVISION_COUNT == '0) ? 32'(DIV_DEFAULT)
                                                              : 32'(DIVISION_COUNT)); // [R6]
  assign fb_rel = fb_wrapped % $signed((div_size == '0) ? 32'h1 : div_size);
  assign on_boundary = (fb_rel == 32'sd0);

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      last_fb_reg <= '0;
      wrap_division_pulse <= 1'b0;
    end else begin
      last_fb_reg <= fb_wrapped;
      // Pulse once on arriving at a boundary, not while parked on it
      // The first cycle after reset has no previous position, so no pulse
      wrap_division_pulse <= WRAP_ENABLE && !home_outside && on_boundary
                             && !first_cycle_reg
                             && (fb_wrapped != last_fb_reg); // [R5] [R7]
    end
  end

  // ----------------------------------------
  // Monitor link synchronisers
  // ----------------------------------------
  logic [1:0] req_a_sync;
  logic [1:0] req_b_sync;
  logic [1:0] clk_sync;
  logic clk_last_reg;
  logic clk_rise;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      req_a_sync <= 2'b00;
      req_b_sync <= 2'b00;
      clk_sync <= 2'b00;
      clk_last_reg <= 1'b0;
    end else begin
      req_a_sync <= {req_a_sync[0], monitor_request_a};
      req_b_sync <= {req_b_sync[0], monitor_request_b};
      clk_sync <= {clk_sync[0], monitor_shift_clock};
      clk_last_reg <= clk_sync[1];
    end
  end
  assign clk_rise = clk_sync[1] && !clk_last_reg;

  // ----------------------------------------
  // Frame build and two-entry buffer
  // ----------------------------------------
  logic [POS_W-1:0] cap_fb_reg, cap_fbc_reg, cap_cmd_reg, cap_cmdc_reg;
  logic [ALM_W-1:0] cap_alarm_reg;
  logic use_b_reg;
  frame_t frame_next;
  frame_t buf_reg [2];
  logic [1:0] buf_count_reg;
  logic buf_wr_ptr_reg, buf_rd_ptr_reg;
  logic in_valid, in_ready, out_valid, out_ready;

  // Payload per request input, bytes summed into the checksum
  always_comb begin
    logic [3:0] sel;
    logic [POS_W-1:0] pos;
    logic [7:0] sum;
    sum = 8'h00;
    sel = use_b_reg ? SELECT_B : SELECT_A; // [R17]
    pos = '0;
    unique case (sel)
      SEL_FB_POS: pos = cap_fb_reg;
      SEL_FB_CNT: pos = cap_fbc_reg;
      SEL_CMD_POS: pos = cap_cmd_reg;
      SEL_CMD_CNT: pos = cap_cmdc_reg;
      default: pos = '0;
    endcase
    if (sel >= SEL_FB_POS && sel <= SEL_CMD_CNT) begin
      sum = pos[7:0] + pos[15:8] + pos[23:16] + pos[31:24] + cap_alarm_reg; // [R16]
      frame_next.bits = {sum, cap_alarm_reg, pos}; // [R15]
      frame_next.len = 6'd48;
    end else begin
      sum = cap_alarm_reg;
      frame_next.bits = {32'h0, sum, cap_alarm_reg};
      frame_next.len = 6'd16;
    end
  end

  // ----------------------------------------
  // Serializer
  // ----------------------------------------
  ser_state_t state_reg;
  logic [FRAME_W-1:0] shift_reg;
  logic [5:0] left_reg;
  logic req_any;

  assign req_any = req_a_sync[1] || req_b_sync[1];
  assign in_valid = (state_reg == SER_LOAD);
  assign in_ready = (buf_count_reg != 2'd2);
  assign out_valid = (buf_count_reg != 2'd0);
  assign out_ready = (state_reg == SER_LOAD) && (left_reg == '0);

  // Buffer entries; aborted frames are flushed with the request
  always_ff @(posedge MCLK) begin
    if (!NRST || !req_any) begin
      buf_count_reg <= 2'd0;
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_reg[buf_wr_ptr_reg] <= frame_next;
        buf_wr_ptr_reg <= !buf_wr_ptr_reg;
      end
      if (out_valid && out_ready) begin
        buf_rd_ptr_reg <= !buf_rd_ptr_reg;
      end
      buf_count_reg <= buf_count_reg + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state_reg <= SER_IDLE;
      shift_reg <= '0;
      left_reg <= '0;
      use_b_reg <= 1'b0;
      monitor_serial_out <= 1'b0;
      cap_fb_reg <= '0;
      cap_fbc_reg <= '0;
      cap_cmd_reg <= '0;
      cap_cmdc_reg <= '0;
      cap_alarm_reg <= '0;
    end else if (!req_any) begin
      state_reg <= SER_IDLE; // [R22]
      left_reg <= '0;
      monitor_serial_out <= 1'b0;
    end else begin
      unique case (state_reg)
        SER_IDLE: begin
          // Snapshot taken at the request edge
          cap_fb_reg <= fb_wrapped; // [R19]
          cap_fbc_reg <= FEEDBACK_COUNTER;
          cap_cmd_reg <= cmd_wrapped;
          cap_cmdc_reg <= COMMAND_COUNTER;
          cap_alarm_reg <= ALARM_CODE;
          use_b_reg <= req_b_sync[1] && !req_a_sync[1];
          state_reg <= SER_LOAD; // [R12]
        end
        SER_LOAD: begin
          if (out_valid) begin
            shift_reg <= buf_reg[buf_rd_ptr_reg].bits;
            left_reg <= buf_reg[buf_rd_ptr_reg].len;
            monitor_serial_out <= 1'b1; // [R19]
            state_reg <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          // Rising edge of shift clock presents the next bit
          if (clk_rise && left_reg != '0) begin
            monitor_serial_out <= shift_reg[0]; // [R13] [R14]
            shift_reg <= {1'b0, shift_reg[FRAME_W-1:1]};
            left_reg <= left_reg - 6'd1;
          end else if (clk_rise) begin
            monitor_serial_out <= 1'b0; // Frame done, hold low until request drops
          end
        end
        default: state_reg <= SER_IDLE;
      endcase
    end
  end

endmodule // wrap_coordinate_position_monitor
`default_nettype wire

// File: sim/wcpm_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port-level checker
// ----------------------------------------
module wcpm_checker
  import wrap_monitor_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic WRAP_ENABLE,
  input wire logic LIMIT_DISABLE,
  input wire logic PROTECT_DISABLE,
  input wire logic HOMED,
  input wire logic MOVE_REQUEST,
  input wire logic [POS_W-1:0] FEEDBACK_COUNTER,
  input wire logic [POS_W-1:0] LIMIT_HIGH,
  input wire logic [SPD_W-1:0] RUN_SPEED,
  input wire logic [SPD_W-1:0] RUN_SPEED_MAX,
  input wire logic monitor_request_a,
  input wire logic monitor_request_b,
  input wire logic monitor_shift_clock,
  input wire logic monitor_serial_out,
  input wire logic WRAP_SETTING_INFO,
  input wire logic [ALM_W-1:0] ALARM_CODE,
  input wire logic wrap_division_pulse
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  chk_pulse_needs_wrap: assert property (
    !WRAP_ENABLE && !$past(WRAP_ENABLE) |-> !wrap_division_pulse) else $error("pulse while off");
  chk_pulse_single: assert property (
    wrap_division_pulse && $stable(FEEDBACK_COUNTER) |=> !wrap_division_pulse)
    else $error("pulse too long");
  chk_info_needs_wrap: assert property (
    !WRAP_ENABLE && !$past(WRAP_ENABLE) |-> !WRAP_SETTING_INFO) else $error("info while off");
  chk_idle_out_low: assert property (
    (!monitor_request_a && !monitor_request_b) [*5] |-> !monitor_serial_out)
    else $error("output high without request");
  chk_ready_after_req: assert property (
    $rose(monitor_request_a) |-> ##[2:8] (monitor_serial_out || !monitor_request_a))
    else $error("no ready");
  // Ready edge is excluded by the held-request window
  chk_bit_on_clock: assert property (
    monitor_request_a [*8] ##0 $changed(monitor_serial_out)
    |-> $past(monitor_shift_clock, 3) && !$past(monitor_shift_clock, 7))
    else $error("output moved off clock");
  chk_alarm_holds: assert property (
    ALARM_CODE != ALM_NONE |=> ALARM_CODE != ALM_NONE) else $error("alarm cleared");
  chk_limit_off: assert property (
    $past(LIMIT_DISABLE, 2) && $past(ALARM_CODE) != ALM_MECH_OVERTRAVEL
    |-> ALARM_CODE != ALM_MECH_OVERTRAVEL)
    else $error("overtravel while disabled");
  chk_protect_off: assert property (
    $past(PROTECT_DISABLE, 2) && $past(ALARM_CODE) != ALM_OP_DATA
    |-> ALARM_CODE != ALM_OP_DATA)
    else $error("speed alarm while disabled");
  chk_overtravel_seen: assert property (
    HOMED && !LIMIT_DISABLE && FEEDBACK_COUNTER == LIMIT_HIGH |-> ##[1:4] ALARM_CODE != 8'h00)
    else $error("no overtravel alarm");
  chk_speed_seen: assert property (
    MOVE_REQUEST && !PROTECT_DISABLE && RUN_SPEED > RUN_SPEED_MAX
    |-> ##[1:4] ALARM_CODE != 8'h00) else $error("no speed alarm");
  cov_pulse: cover property (wrap_division_pulse);
  cov_ready: cover property ($rose(monitor_serial_out));
  cov_speed: cover property (ALARM_CODE == ALM_OP_DATA);
endmodule // wcpm_checker
bind wrap_coordinate_position_monitor wcpm_checker i_chk (.*);
`default_nettype wire

// File: sim/monitor_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the monitor link
// ----------------------------------------
module monitor_host_model (
  input wire logic monitor_serial_out,
  output logic monitor_request_a,
  output logic monitor_request_b,
  output logic monitor_shift_clock
);
  // Shift clock stands still low outside frames
  initial begin
    monitor_request_a = 1'b0;
    monitor_request_b = 1'b0;
    monitor_shift_clock = 1'b0;
  end
  // One frame per raised request; fewer bits ends it early
  task automatic read_frame(input bit use_b, input int nbits, output logic [47:0] d,
                            output bit ok);
    ok = 1'b0;
    d = '0;
    if (use_b) begin
      monitor_request_b = 1'b1;
    end else begin
      monitor_request_a = 1'b1;
    end
    for (int i = 0; i < 40 && !ok; i++) begin
      #50 ok = (monitor_serial_out === 1'b1);
    end
    // Read late in the low phase, well clear of the output update
    for (int i = 0; i < nbits && ok; i++) begin
      monitor_shift_clock = 1'b1;
      #200 monitor_shift_clock = 1'b0;
      #200 d[i] = monitor_serial_out;
    end
    monitor_request_a = 1'b0;
    monitor_request_b = 1'b0;
    #500;
  endtask
endmodule // monitor_host_model
`default_nettype wire

// File: sim/wrap_coordinate_position_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Testbench
// ----------------------------------------
module wrap_coordinate_position_monitor_test;
  import wrap_monitor_pkg::*;
  logic MCLK = 0, NRST = 0, WRAP_ENABLE = 0, LIMIT_DISABLE = 0, PROTECT_DISABLE = 0;
  logic CONFIG_EXECUTE = 0, HOMED = 0, MOVE_REQUEST = 0;
  logic [POS_W-1:0] WRAP_RANGE_STEPS = 32'h3e8, WRAP_OFFSET_STEPS = '0, FEEDBACK_COUNTER = '0;
  logic [POS_W-1:0] COMMAND_COUNTER = '0, LIMIT_LOW = 32'hfffffc18, LIMIT_HIGH = 32'h3e8;
  logic [RATIO_W-1:0] WRAP_OFFSET_RATIO = '0;
  logic [DIV_W-1:0] DIVISION_COUNT = DIV_DEFAULT;
  logic [SPD_W-1:0] START_SPEED = '0, RUN_SPEED = '0;
  logic [SPD_W-1:0] START_SPEED_MAX = 24'h0003e8, RUN_SPEED_MAX = 24'h0003e8;
  logic [3:0] SELECT_A = SEL_A_DEFAULT, SELECT_B = SEL_B_DEFAULT;
  wire logic monitor_request_a, monitor_request_b, monitor_shift_clock;
  logic monitor_serial_out, WRAP_SETTING_INFO, wrap_division_pulse;
  logic [ALM_W-1:0] ALARM_CODE;
  logic [47:0] d;
  bit ok;
  int mismatches = 0, compares = 0;
  always #25 MCLK = ~MCLK;
  wrap_coordinate_position_monitor i_dut (.*);
  monitor_host_model i_host (.*);
  task automatic compare(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge MCLK) NRST = 0;
    repeat (10) @(negedge MCLK);
    NRST = 1;
    repeat (4) @(negedge MCLK);
  endtask
  // Checksum truncates to a byte because the concatenation is self-sized
  function automatic logic [47:0] frame(input logic [31:0] p, input logic [7:0] a);
    return {p[7:0] + p[15:8] + p[23:16] + p[31:24] + a, a, p};
  endfunction
  task automatic test_frames();
    FEEDBACK_COUNTER = 32'hfffffed4;
    COMMAND_COUNTER = 32'h000002bc;
    for (int i = 0; i < 4; i++) begin
      SELECT_B = 4'(SEL_FB_POS + i);
      i_host.read_frame(1'b1, 48, d, ok);
      compare(48'(ok), 48'h1);
      compare(d, frame(i < 2 ? FEEDBACK_COUNTER : COMMAND_COUNTER, ALM_NONE));
    end
    SELECT_A = SEL_FB_CNT;
    i_host.read_frame(1'b0, 20, d, ok);
    compare(d, frame(FEEDBACK_COUNTER, ALM_NONE) & 48'hfffff);
    compare(48'(monitor_serial_out), 48'h0);
    i_host.read_frame(1'b0, 48, d, ok);
    compare(d, frame(FEEDBACK_COUNTER, ALM_NONE));
  endtask
  task automatic test_wrap_info();
    logic [RATIO_W-1:0] r [6] = '{14'h1388, 14'h1388, 14'h1388, 14'h0, 14'h0, RATIO_FULL};
    logic [31:0] o [6] = '{32'h0, 32'h1f4, 32'h1f5, 32'h0, 32'h1, 32'h0};
    logic e [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    WRAP_ENABLE = 1;
    for (int i = 0; i < 6; i++) begin
      WRAP_OFFSET_RATIO = r[i];
      WRAP_OFFSET_STEPS = o[i];
      repeat (4) @(negedge MCLK);
      compare(48'(WRAP_SETTING_INFO), 48'(e[i]));
    end
    CONFIG_EXECUTE = 1;
    @(negedge MCLK) CONFIG_EXECUTE = 0;
    repeat (4) @(negedge MCLK);
    compare(48'(ALARM_CODE), 48'(ALM_WRAP_SETTING));
    do_reset();
    compare(48'(ALARM_CODE), 48'(ALM_WRAP_SETTING));
    WRAP_OFFSET_RATIO = '0;
    do_reset();
    // Window -500..499 folds command 700 onto -300; the counter code stays raw
    WRAP_OFFSET_RATIO = 14'h1388;
    SELECT_A = SEL_CMD_POS;
    i_host.read_frame(1'b0, 48, d, ok);
    compare(d, frame(32'hfffffed4, ALM_NONE));
    SELECT_A = SEL_CMD_CNT;
    i_host.read_frame(1'b0, 48, d, ok);
    compare(d, frame(32'h000002bc, ALM_NONE));
    WRAP_OFFSET_RATIO = '0;
  endtask
  // Walk one lap of a 0..999 window; the last step wraps onto home
  task automatic test_division();
    int n;
    logic [DIV_W-1:0] cnt [3] = '{29'h4, DIV_DEFAULT, 29'h4};
    int exp [3] = '{4, 1, 0};
    for (int k = 0; k < 3; k++) begin
      WRAP_ENABLE = (k < 2);
      DIVISION_COUNT = cnt[k];
      FEEDBACK_COUNTER = 32'h1;
      repeat (4) @(negedge MCLK);
      n = 0;
      for (int v = 2; v < 1005; v++) begin
        @(negedge MCLK) FEEDBACK_COUNTER = (v > 1000) ? 32'h3e8 : 32'(v);
        n += (wrap_division_pulse === 1'b1);
      end
      compare(48'(n), 48'(exp[k]));
    end
  endtask
  task automatic test_limit();
    HOMED = 1;
    LIMIT_DISABLE = 1;
    repeat (6) @(negedge MCLK);
    compare(48'(ALARM_CODE), 48'(ALM_NONE));
    LIMIT_DISABLE = 0;
    repeat (6) @(negedge MCLK);
    compare(48'(ALARM_CODE), 48'(ALM_MECH_OVERTRAVEL));
    SELECT_A = SEL_ALARM;
    i_host.read_frame(1'b0, 16, d, ok);
    compare(d, {32'h0, ALM_MECH_OVERTRAVEL, ALM_MECH_OVERTRAVEL});
    HOMED = 0;
  endtask
  // Start ceiling first, then the run ceiling; the other sits exactly at its max
  task automatic test_speed();
    for (int k = 0; k < 2; k++) begin
      do_reset();
      MOVE_REQUEST = 1;
      PROTECT_DISABLE = 1;
      START_SPEED = k ? 24'h0003e8 : 24'h0003e9;
      RUN_SPEED = k ? 24'h0003e9 : 24'h0003e8;
      repeat (6) @(negedge MCLK);
      compare(48'(ALARM_CODE), 48'(ALM_NONE));
      PROTECT_DISABLE = 0;
      repeat (6) @(negedge MCLK);
      compare(48'(ALARM_CODE), 48'(ALM_OP_DATA));
      // Idle the move so the next reset release does not latch the alarm again
      MOVE_REQUEST = 0;
    end
  endtask
  initial begin
    do_reset();
    compare(48'({monitor_serial_out, WRAP_SETTING_INFO, ALARM_CODE, wrap_division_pulse}),
            48'h0);
    test_frames();
    test_wrap_info();
    test_division();
    test_limit();
    test_speed();
    complete_run();
  end
  // Watchdog: run needs well under half this span
  initial begin
    #2000000;
    mismatches++;
    complete_run();
  end
endmodule // wrap_coordinate_position_monitor_test
`default_nettype wire
